// File: hw/iox_port_drive.v
// Pin driver control for one eight-bit port
`include "iox_defs.vh"
`timescale 1ns/1ns
module iox_port_drive
(
  input  wire       clk,
  input  wire       nrst,
  input  wire [7:0] drive_level,
  input  wire [7:0] direction,
  output reg  [7:0] pin_out,
  output reg  [7:0] pin_oe
);

  // Registered so the pins cannot glitch on decode
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out <= `IOX_RST_DRV;
      pin_oe  <= 8'h00;
    end
    else
    begin
      pin_out <= drive_level;
      pin_oe  <= ~direction;
    end
  end

endmodule // iox_port_drive

// File: hw/iox_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module iox_sync
#(
  parameter WIDTH = 21
)
(
  input  wire             clk,
  input  wire             nrst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second; reset value low
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // iox_sync

// File: hw/iox_top.v
// Two-wire slave I/O expander: bus engine, registers, interrupt
`include "iox_defs.vh"
`timescale 1ns/1ns
module iox_top
(
  input  wire       clk,
  input  wire       nrst,
  input  wire       addr_sel_bit0,
  input  wire       addr_sel_bit1,
  input  wire       addr_sel_bit2,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire [7:0] port_low_in,
  input  wire [7:0] port_high_in,
  output wire [7:0] port_low_out,
  output wire [7:0] port_low_oe,
  output wire [7:0] port_high_out,
  output wire [7:0] port_high_oe,
  output reg        int_n_out,
  output reg        int_n_oe
);

  // Bus engine states
  localparam ST_IDLE  = 4'h0;
  localparam ST_ADDR  = 4'h1;
  localparam ST_AACK  = 4'h2;
  localparam ST_CMD   = 4'h3;
  localparam ST_CACK  = 4'h4;
  localparam ST_WDATA = 4'h5;
  localparam ST_WACK  = 4'h6;
  localparam ST_RDATA = 4'h7;
  localparam ST_RACK  = 4'h8;

  wire [20:0] sync_bus;
  wire        scl_s;
  wire        sda_s;
  wire [2:0]  addr_sel;
  wire [15:0] pin_s;

  reg         scl_d;
  reg         sda_d;
  reg  [3:0]  state;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  rx_shift;
  reg  [7:0]  tx_shift;
  reg         rw_bit;
  reg         nack;
  reg  [2:0]  ptr;
  reg  [15:0] drive_level;
  reg  [15:0] invert;
  reg  [15:0] direction;
  reg  [15:0] int_ref;
  reg         ref_valid;
  reg  [1:0]  ref_wait;
  reg  [7:0]  cap_raw;

  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;
  wire [6:0]  own_addr;
  wire [15:0] pin_view;
  wire [15:0] changed;
  wire [7:0]  rd_cur;
  wire [7:0]  rd_pair;

  // All pins are asynchronous to clk
  iox_sync #(.WIDTH(21)) u_sync
  (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({scl_in, sda_in, addr_sel_bit2, addr_sel_bit1, addr_sel_bit0,
                port_high_in, port_low_in}),
    .sync_out (sync_bus)
  );

  assign scl_s    = sync_bus[20];
  assign sda_s    = sync_bus[19];
  assign addr_sel = sync_bus[18:16];
  assign pin_s    = sync_bus[15:0];

  // Bus events from the synchronised lines
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  assign own_addr  = {`IOX_ADDR_FIXED, addr_sel};

  // Level seen by software, inverted per bit
  assign pin_view = pin_s ^ invert;

  // Only input pins that moved from the reference count
  assign changed = (pin_s ^ int_ref) & direction;

  // Register readback by pointer; low three bits only
  function [7:0] reg_read;
    input [2:0]  sel;
    input [15:0] view;
    input [15:0] drv;
    input [15:0] inv;
    input [15:0] dir;
    begin
      if (sel == `IOX_REG_PIN_LO)
        reg_read = view[7:0];
      else if (sel == `IOX_REG_PIN_HI)
        reg_read = view[15:8];
      else if (sel == `IOX_REG_DRV_LO)
        reg_read = drv[7:0];
      else if (sel == `IOX_REG_DRV_HI)
        reg_read = drv[15:8];
      else if (sel == `IOX_REG_INV_LO)
        reg_read = inv[7:0];
      else if (sel == `IOX_REG_INV_HI)
        reg_read = inv[15:8];
      else if (sel == `IOX_REG_DIR_LO)
        reg_read = dir[7:0];
      else
        reg_read = dir[15:8];
    end
  endfunction

  // Other register of the same pair
  function [2:0] pair_next;
    input [2:0] sel;
    begin
      pair_next = sel ^ 3'h1;
    end
  endfunction

  // True for the two input registers
  function is_pin_reg;
    input [2:0] sel;
    begin
      is_pin_reg = (sel[2:1] == 2'b00);
    end
  endfunction

  // Byte to send now, and the one after a master ack
  assign rd_cur  = reg_read(ptr, pin_view, drive_level, invert, direction);
  assign rd_pair = reg_read(pair_next(ptr), pin_view, drive_level, invert, direction);

  // Previous line levels for edge finding
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus engine and register file
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state       <= ST_IDLE;
      bit_cnt     <= 4'h0;
      rx_shift    <= 8'h00;
      tx_shift    <= 8'h00;
      rw_bit      <= 1'b0;
      nack        <= 1'b0;
      sda_oe      <= 1'b0;
      ptr         <= `IOX_RST_PTR;
      drive_level <= {`IOX_RST_DRV, `IOX_RST_DRV};
      invert      <= {`IOX_RST_INV, `IOX_RST_INV};
      direction   <= {`IOX_RST_DIR, `IOX_RST_DIR};
      cap_raw     <= 8'h00;
    end
    else if (bus_stop)
    begin
      // A stop ends anything, and frees the data line
      state   <= ST_IDLE;
      sda_oe  <= 1'b0;
      bit_cnt <= 4'h0;
    end
    else if (bus_start)
    begin
      // Start or repeated start; pointer is kept for reads
      state   <= ST_ADDR;
      sda_oe  <= 1'b0;
      bit_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (scl_rise && bit_cnt != `IOX_BYTE_BITS)
          begin
            rx_shift <= {rx_shift[6:0], sda_s};
            bit_cnt  <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == `IOX_BYTE_BITS)
          begin
            bit_cnt <= 4'h0;
            if (state == ST_ADDR)
            begin
              if (rx_shift[7:1] == own_addr)
              begin
                rw_bit <= rx_shift[0];
                sda_oe <= 1'b1;
                state  <= ST_AACK;
              end
              else
              begin
                state <= ST_IDLE;
              end
            end
            else if (state == ST_CMD)
            begin
              ptr    <= rx_shift[2:0];
              sda_oe <= 1'b1;
              state  <= ST_CACK;
            end
            else
            begin
              // Input registers silently drop writes
              if (ptr == `IOX_REG_DRV_LO)
                drive_level[7:0] <= rx_shift;
              else if (ptr == `IOX_REG_DRV_HI)
                drive_level[15:8] <= rx_shift;
              else if (ptr == `IOX_REG_INV_LO)
                invert[7:0] <= rx_shift;
              else if (ptr == `IOX_REG_INV_HI)
                invert[15:8] <= rx_shift;
              else if (ptr == `IOX_REG_DIR_LO)
                direction[7:0] <= rx_shift;
              else if (ptr == `IOX_REG_DIR_HI)
                direction[15:8] <= rx_shift;
              ptr    <= pair_next(ptr);
              sda_oe <= 1'b1;
              state  <= ST_WACK;
            end
          end
        end

        ST_AACK:
        begin
          if (scl_fall)
          begin
            if (rw_bit)
            begin
              // Snapshot taken at the ack clock fall
              tx_shift <= rd_cur;
              cap_raw  <= ptr[0] ? pin_s[15:8] : pin_s[7:0];
              sda_oe   <= ~rd_cur[7];
              state    <= ST_RDATA;
            end
            else
            begin
              sda_oe <= 1'b0;
              state  <= ST_CMD;
            end
          end
        end

        ST_CACK, ST_WACK:
        begin
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            state  <= ST_WDATA;
          end
        end

        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == `IOX_LAST_BIT)
            begin
              sda_oe  <= 1'b0;
              bit_cnt <= 4'h0;
              state   <= ST_RACK;
            end
            else
            begin
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_oe   <= ~tx_shift[6];
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
        end

        ST_RACK:
        begin
          if (scl_rise)
          begin
            nack <= sda_s;
          end
          else if (scl_fall)
          begin
            // Pointer moves on even after the last byte
            ptr <= pair_next(ptr);
            if (!nack)
            begin
              tx_shift <= rd_pair;
              cap_raw  <= ptr[0] ? pin_s[7:0] : pin_s[15:8];
              sda_oe   <= ~rd_pair[7];
              state    <= ST_RDATA;
            end
            else
            begin
              state <= ST_IDLE;
            end
          end
        end

        default:
        begin
          sda_oe <= 1'b0;
          state  <= ST_IDLE;
        end
      endcase
    end
  end

  // Interrupt reference: taken after reset, renewed by input reads
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_ref   <= 16'h0000;
      ref_valid <= 1'b0;
      ref_wait  <= 2'h0;
    end
    else if (!ref_valid)
    begin
      // Synchroniser resets low; wait until it shows the pins, else a false interrupt
      int_ref   <= pin_s;
      ref_wait  <= ref_wait + 2'h1;
      ref_valid <= (ref_wait == 2'h2);
    end
    else if (state == ST_RACK && scl_rise && !bus_start && !bus_stop && is_pin_reg(ptr))
    begin
      // Uses the snapshot, so a change since capture stays pending
      if (ptr[0])
        int_ref[15:8] <= cap_raw;
      else
        int_ref[7:0] <= cap_raw;
    end
  end

  // Open-drain interrupt; low side only, released when equal
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_n_out <= 1'b0;
      int_n_oe  <= 1'b0;
    end
    else
    begin
      int_n_out <= 1'b0;
      int_n_oe  <= ref_valid & (|changed);
    end
  end

  // Data line only ever pulled low
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // Pin drivers per port
  iox_port_drive u_drive_low
  (
    .clk         (clk),
    .nrst        (nrst),
    .drive_level (drive_level[7:0]),
    .direction   (direction[7:0]),
    .pin_out     (port_low_out),
    .pin_oe      (port_low_oe)
  );

  iox_port_drive u_drive_high
  (
    .clk         (clk),
    .nrst        (nrst),
    .drive_level (drive_level[15:8]),
    .direction   (direction[15:8]),
    .pin_out     (port_high_out),
    .pin_oe      (port_high_oe)
  );

endmodule // iox_top

// File: shared/iox_defs.vh
// Constants for the 16-bit two-wire I/O expander
//
// Operation
// - Match address against three select pins
// - Address upper four bits fixed 0100
// - Last address bit 1 read, 0 write
// - Byte after write address is pointer
// - Pointer selects eight registers, 00h-07h
// - Input registers show pins; writes ignored
// - Drive bits affect output pins only
// - Drive register reads return written value
// - Invert bit flips input register bit
// - Direction 1 input, 0 output
// - Output pin drives its drive bit
// - Reset gives documented register defaults
// - Input pin edge raises interrupt
// - Clear on reversion or input read
// - Read clear at acknowledge rising edge
// - Later changes raise interrupt again
// - Output pins never raise interrupt
// - Interrupt open-drain, active low
// - Write: address, command, then data
// - Written bytes alternate within pair
// - Any number of written bytes
// - Read via repeated start, alternating pair
// - Read byte captured at ack fall
`ifndef IOX_DEFS_VH
`define IOX_DEFS_VH

// Fixed upper part of the slave address
`define IOX_ADDR_FIXED      4'b0100

// Register selects
`define IOX_REG_PIN_LO      3'h0
`define IOX_REG_PIN_HI      3'h1
`define IOX_REG_DRV_LO      3'h2
`define IOX_REG_DRV_HI      3'h3
`define IOX_REG_INV_LO      3'h4
`define IOX_REG_INV_HI      3'h5
`define IOX_REG_DIR_LO      3'h6
`define IOX_REG_DIR_HI      3'h7

// Reset values
`define IOX_RST_DRV         8'hff
`define IOX_RST_INV         8'h00
`define IOX_RST_DIR         8'hff
`define IOX_RST_PTR         3'h0

// Bits per byte on the wire
`define IOX_BYTE_BITS       4'h8
`define IOX_LAST_BIT        4'h7

`endif

// File: tb/iox_master.sv
// Behavioural two-wire bus master facing the expander
`timescale 1ns/1ns
module iox_master
(
  output logic scl,
  output logic sda_pull,
  input  wire  sda
);
  // Clock stands high and data released between frames
  initial
  begin
    scl      = 1'h1;
    sda_pull = 1'h0;
  end
  // Start from idle or repeated start inside a frame
  // Steps land on clk edges, so lines move by non-blocking assignment
  task automatic start();
    sda_pull <= 1'h0;
    #40 scl <= 1'h1;
    #40 sda_pull <= 1'h1;
    #40 scl <= 1'h0;
    #40;
  endtask
  task automatic stop();
    sda_pull <= 1'h1;
    #40 scl <= 1'h1;
    #40 sda_pull <= 1'h0;
    #80;
  endtask
  // Data only changes mid clock-low
  task automatic bit_out(input logic b);
    sda_pull <= !b;
    #40 scl <= 1'h1;
    #80 scl <= 1'h0;
    #40;
  endtask
  task automatic bit_in(output logic b);
    sda_pull <= 1'h0;
    #40 scl <= 1'h1;
    #40 b = sda;
    #40 scl <= 1'h0;
    #40;
  endtask
  // Byte out, most significant first; last bit of an address is direction
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(b);
    ack = !b;
  endtask
  // Last byte of a read is refused so the device lets go
  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(last);
  endtask
endmodule // iox_master

// File: tb/iox_props.sv
// Port-level assertions for the two-wire I/O expander
`timescale 1ns/1ns
module iox_props
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] port_low_in,
  input wire logic [7:0] port_high_in,
  input wire logic [7:0] port_low_out,
  input wire logic [7:0] port_low_oe,
  input wire logic [7:0] port_high_out,
  input wire logic [7:0] port_high_oe,
  input wire logic       int_n_out,
  input wire logic       int_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Cycles since a pin or direction moved; direction flips may also raise INT
  logic [31:0] prev;
  logic [3:0]  quiet;
  wire  [31:0] now_v = {port_low_in, port_high_in, port_low_oe, port_high_oe};
  // Quiet lags a cycle; a change seen in this sample counts as age zero
  wire  [3:0]  age   = (now_v != prev) ? 4'h0 : quiet;
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      prev  <= 32'h0;
      quiet <= 4'h0;
    end
    else
    begin
      prev  <= now_v;
      quiet <= (now_v != prev) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
    end
  // Steps used by the checks; only the clock-low step is shared, by two
  sequence s_all_out;
    (port_low_oe == 8'hff && port_high_oe == 8'hff) [*8];
  endsequence
  sequence s_scl_low;
    !scl_in;
  endsequence
  a_reset_defaults: assert property ($rose(nrst) |-> port_low_out == 8'hff
    && port_high_out == 8'hff && port_low_oe == 8'h00 && port_high_oe == 8'h00)
    else $error("pin defaults wrong after reset");
  a_line_zero: assert property (!sda_out && !int_n_out)
    else $error("open-drain data level not low");
  a_out_pins_quiet: assert property (s_all_out |-> !int_n_oe)
    else $error("interrupt with every pin an output");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> s_scl_low)
    else $error("data line pulled while clock high");
  a_drive_scl_low: assert property ($changed({port_low_out, port_high_out}) |-> s_scl_low)
    else $error("drive level moved outside clock low");
  a_dir_scl_low: assert property ($changed({port_low_oe, port_high_oe}) |->
    !scl_in ##1 !scl_in)
    else $error("direction moved outside clock low");
  a_int_rise_cause: assert property ($rose(int_n_oe) |-> age < 4'h8)
    else $error("interrupt rose without pin change");
  a_int_fall_cause: assert property ($fell(int_n_oe) |-> age < 4'h8 || scl_in)
    else $error("interrupt fell without reversion or read");
endmodule // iox_props

bind iox_top iox_props u_iox_props (.*);

// File: tb/tb_i2c_sixteen_bit_io_expander.sv
// Self-checking bench for the two-wire I/O expander
`timescale 1ns/1ns
module tb_i2c_sixteen_bit_io_expander;
  localparam logic [6:0] DEV = 7'h25;
  logic       clk, nrst, scl, sda_pull, sda_oe, sda_out, int_n_out, int_n_oe, ack;
  logic [7:0] ext_lo, ext_hi, lo_out, lo_oe, hi_out, hi_oe, rd_a, rd_b;
  int         n_fail, checks_done;
  // Pulled-up data line; pins show driver where enabled, else outside level
  wire        sda    = !(sda_pull | sda_oe);
  wire  [7:0] lo_pin = (lo_oe & lo_out) | (~lo_oe & ext_lo);
  wire  [7:0] hi_pin = (hi_oe & hi_out) | (~hi_oe & ext_hi);

  iox_top u_iox_top (.clk(clk), .nrst(nrst), .addr_sel_bit0(1'h1), .addr_sel_bit1(1'h0),
    .addr_sel_bit2(1'h1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .port_low_in(lo_pin), .port_high_in(hi_pin), .port_low_out(lo_out), .port_low_oe(lo_oe),
    .port_high_out(hi_out), .port_high_oe(hi_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
  iox_master u_iox_master (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h0, exp}, {7'h0, got});
  endtask
  task automatic addr(input logic [6:0] a, input logic rw, input logic exp_ack);
    u_iox_master.wr_byte({a, rw}, ack);
    chk1("address ack", exp_ack, ack);
  endtask
  // Command then two data bytes, alternating within the pair
  task automatic wr2(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] b);
    u_iox_master.start();
    addr(DEV, 1'h0, 1'h1);
    u_iox_master.wr_byte(cmd, ack);
    u_iox_master.wr_byte(a, ack);
    u_iox_master.wr_byte(b, ack);
    u_iox_master.stop();
  endtask
  task automatic rd2(input logic [7:0] cmd);
    u_iox_master.start();
    addr(DEV, 1'h0, 1'h1);
    u_iox_master.wr_byte(cmd, ack);
    u_iox_master.start();
    addr(DEV, 1'h1, 1'h1);
    u_iox_master.rd_byte(1'h0, rd_a);
    u_iox_master.rd_byte(1'h1, rd_b);
    u_iox_master.stop();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #400000;
    n_fail++;
    give_verdict();
  end

  initial
  begin
    nrst        = 1'h0;
    ext_lo      = 8'h3c;
    ext_hi      = 8'hc3;
    n_fail      = 0;
    checks_done = 0;
    wclk(2);
    nrst <= 1'h1;
    wclk(8);
    chk8("low oe", 8'h00, lo_oe);
    chk1("int after reset", 1'h0, int_n_oe);
    for (int k = 2; k < 8; k += 2)
    begin
      rd2(k[7:0]);
      chk8("reset low", (k == 4) ? 8'h00 : 8'hff, rd_a);
      chk8("reset high", (k == 4) ? 8'h00 : 8'hff, rd_b);
    end
    $display("test defaults done");
    wr2(8'h03, 8'h5a, 8'ha5);
    wr2(8'h06, 8'hf0, 8'h0f);
    wr2(8'h00, 8'h11, 8'h22);
    wclk(4);
    chk8("low out", 8'ha5, lo_out);
    chk8("high out", 8'h5a, hi_out);
    chk8("low oe", 8'h0f, lo_oe);
    chk8("high oe", 8'hf0, hi_oe);
    rd2(8'hfa);
    chk8("drive low", 8'ha5, rd_a);
    chk8("drive high", 8'h5a, rd_b);
    $display("test pairs done");
    wr2(8'h04, 8'hff, 8'h00);
    rd2(8'h00);
    chk8("input low", 8'hca, rd_a);
    chk8("input high", 8'h53, rd_b);
    chk1("int idle", 1'h0, int_n_oe);
    $display("test inputs done");
    wr2(8'h02, 8'ha4, 8'h5a);
    wclk(10);
    chk1("int output pin", 1'h0, int_n_oe);
    ext_lo <= 8'hbc;
    wclk(10);
    chk1("int edge", 1'h1, int_n_oe);
    ext_lo <= 8'h3c;
    wclk(10);
    chk1("int revert", 1'h0, int_n_oe);
    ext_lo <= 8'hbc;
    wclk(10);
    chk1("int again", 1'h1, int_n_oe);
    rd2(8'h00);
    chk8("input low", 8'h4b, rd_a);
    chk1("int read clear", 1'h0, int_n_oe);
    ext_hi <= 8'hc2;
    wclk(10);
    chk1("int rearm", 1'h1, int_n_oe);
    wr2(8'h06, 8'h00, 8'h00);
    wclk(12);
    chk1("int all outputs", 1'h0, int_n_oe);
    $display("test interrupt done");
    for (int k = 0; k < 8; k++)
    begin
      u_iox_master.start();
      addr({4'h4, k[2:0]}, 1'h0, k == 5);
      u_iox_master.stop();
    end
    u_iox_master.start();
    addr(7'h65, 1'h0, 1'h0);
    u_iox_master.stop();
    $display("test address done");
    give_verdict();
  end
endmodule // tb_i2c_sixteen_bit_io_expander
